//--- logic/ptb_pkg.sv
// shared constants and helpers for the pwm time base
`default_nettype none
package ptb_pkg;
  localparam int CNT_W = 14;
  localparam int SEL_W = 3;
  localparam int DIV_W = 15;
  // resolution periods in system clocks for selects 0 to 6
  localparam logic [14:0] RES_0 = 15'h0001;
  localparam logic [14:0] RES_1 = 15'h0002;
  localparam logic [14:0] RES_2 = 15'h0040;
  localparam logic [14:0] RES_3 = 15'h0080;
  localparam logic [14:0] RES_4 = 15'h0100;
  localparam logic [14:0] RES_5 = 15'h0400;
  localparam logic [14:0] RES_6 = 15'h1000;
  // control register fields
  localparam int CTRL_CKS_LSB = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_LOW_FILL = 8'hFF;
  // data register fields
  localparam int DATA_CFS_BIT = 1;
  localparam logic [15:0] DATA_RST = 16'hFFFF;
  localparam logic [13:0] MIN_BASE64 = 14'h0100;
  localparam logic [13:0] MIN_BASE256 = 14'h0040;
  // counter fields
  localparam logic [13:0] CNT_RST = 14'h0000;
  localparam int LOW_RSV_BIT = 1;
  localparam int LOW_BANK_BIT = 0;
  localparam logic BANK_RST = 1'b1;
  localparam logic RSV_READ = 1'b1;

  function automatic logic [5:0] ptb_rev6(input logic [5:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 6; i++) begin
      r[i] = v[5 - i];
    end
    return r;
  endfunction
endpackage
`default_nettype wire

//--- logic/ptb_prescale.sv
// resolution divider: one-cycle tick every selected period
`default_nettype none
module ptb_prescale #(
  parameter logic [14:0] SLOW_PERIOD = 15'h4000
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // control
  input wire logic [2:0] i_sel,
  // tick out
  output logic o_tick
);
  typedef struct packed {
    logic [14:0] div;
    logic tick;
  } ptb_pre_type;
  ptb_pre_type s;
  ptb_pre_type next_s;
  logic [14:0] period;

  always_comb begin
    unique case (i_sel)
      3'h0: period = ptb_pkg::RES_0;
      3'h1: period = ptb_pkg::RES_1;
      3'h2: period = ptb_pkg::RES_2;
      3'h3: period = ptb_pkg::RES_3;
      3'h4: period = ptb_pkg::RES_4;
      3'h5: period = ptb_pkg::RES_5;
      3'h6: period = ptb_pkg::RES_6;
      3'h7: period = SLOW_PERIOD;
    endcase
    next_s = s;
    next_s.tick = 1'b0;
    if (s.div >= period - 15'h0001) begin
      next_s.div = 15'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 15'h0001;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_tick = s.tick;

  tick_period2_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_sel == 3'h1)[*3] ##0 o_tick |=> !o_tick)
    else $error("tick too dense at period two");
endmodule
`default_nettype wire

//--- logic/ptb_channel.sv
// one modulated output: base pulse plus spread fine pulses
`default_nettype none
module ptb_channel (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // time base and data
  input wire logic [13:0] i_count,
  input wire logic [13:0] i_data,
  input wire logic i_cfs,
  // output
  output logic o_pwm
);
  typedef struct packed {
    logic pwm;
  } ptb_ch_type;
  ptb_ch_type s;
  ptb_ch_type next_s;
  logic [13:0] cnt;
  logic [7:0] base;
  logic [7:0] duty;
  logic [7:0] fine;
  logic [7:0] spread;
  logic in_range;

  always_comb begin
    // low two data bits zero selects 12-bit precision
    if (i_data[1:0] == 2'b00) begin
      cnt = {2'b00, i_count[11:0]};
    end else begin
      cnt = i_count;
    end
    if (i_cfs) begin
      base = cnt[7:0];
      duty = i_data[13:6];
      fine = {2'b00, i_data[5:0]};
      spread = {2'b00, ptb_pkg::ptb_rev6(cnt[13:8])};
      in_range = i_data >= ptb_pkg::MIN_BASE256;
    end else begin
      base = {2'b00, cnt[5:0]};
      duty = {2'b00, i_data[13:8]};
      fine = i_data[7:0];
      spread = {ptb_pkg::ptb_rev6(cnt[11:6]), cnt[12], cnt[13]};
      in_range = i_data >= ptb_pkg::MIN_BASE64;
    end
    next_s = s;
    // extra one-resolution pulse spread over base cycles
    next_s.pwm = in_range && ((base < duty) || (base == duty && spread < fine));
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_pwm = s.pwm;

  range_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !in_range |=> !o_pwm)
    else $error("output not held low out of range");
  base_high_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (in_range && base < duty) |=> o_pwm)
    else $error("base pulse missing");
endmodule
`default_nettype wire

//--- logic/ptb_timebase.sv
// time base, staging latch and banked registers of the pwm converter
`default_nettype none
module ptb_timebase #(
  parameter logic [14:0] SLOW_PERIOD = 15'h4000
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // shared address select from serial timer control
  input wire logic i_bus_interface_enable,
  // cpu byte access
  input wire logic i_sel_a,
  input wire logic i_sel_b,
  input wire logic i_byte_low,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // modulated outputs
  output logic o_pwm_out_a,
  output logic o_pwm_out_b
);
  typedef struct packed {
    logic [13:0] cnt;
    logic bank;
    logic [7:0] ctrl;
    logic [15:1] data_a;
    logic [15:1] data_b;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic rvalid;
  } ptb_state_type;

  ptb_state_type s;
  ptb_state_type next_s;

  logic tick;
  logic acc;
  logic hit;
  logic ctrl_hit;
  logic [2:0] counter_clock_select;
  logic [15:0] ctrl_word;
  logic [15:0] cnt_word;
  logic [15:0] da_word;
  logic [15:0] db_word;
  logic [15:0] rd_word;
  logic [15:0] wr_word;

  // resolution divider feeding the counter
  ptb_prescale #(
    .SLOW_PERIOD(SLOW_PERIOD)
  ) u_prescale (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_sel(s.ctrl[ptb_pkg::CTRL_CKS_LSB +: ptb_pkg::SEL_W]),
    .o_tick(tick)
  );

  // register views as seen by the cpu
  always_comb begin
    ctrl_word = {s.ctrl, ptb_pkg::CTRL_LOW_FILL};
    cnt_word = {s.cnt[7:0], ptb_pkg::ptb_rev6(s.cnt[13:8]), ptb_pkg::RSV_READ, s.bank};
    da_word = {s.data_a, ptb_pkg::RSV_READ};
    db_word = {s.data_b, s.bank};
    if (i_sel_a) begin
      rd_word = s.bank ? ctrl_word : da_word;
    end else begin
      rd_word = s.bank ? cnt_word : db_word;
    end
    wr_word = {s.temp, i_wdata};
  end

  // bus decode
  always_comb begin
    acc = !i_bus_interface_enable;
    hit = acc && (i_sel_a || i_sel_b);
    ctrl_hit = i_sel_a && s.bank;
    counter_clock_select = s.ctrl[ptb_pkg::CTRL_CKS_LSB +: ptb_pkg::SEL_W];
  end

  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    // counter advance, a cpu write below takes priority
    if (tick) begin
      next_s.cnt = s.cnt + 14'h0001;
    end
    // reads: high byte returns now and parks low byte
    if (hit && i_rd) begin
      next_s.rvalid = 1'b1;
      if (!i_byte_low) begin
        next_s.rdata = rd_word[15:8];
        next_s.temp = rd_word[7:0];
      end else begin
        next_s.rdata = s.temp;
      end
    end
    // writes: high byte parks except control, which loads at once; low byte commits the word
    if (hit && i_wr) begin
      if (!i_byte_low) begin
        if (ctrl_hit) begin
          next_s.ctrl = i_wdata;
        end else begin
          next_s.temp = i_wdata;
        end
      end else if (i_sel_a) begin
        if (!s.bank) begin
          next_s.data_a = wr_word[15:1];
        end
      end else if (s.bank) begin
        // reserved bit of the low byte is dropped
        next_s.cnt = {ptb_pkg::ptb_rev6(wr_word[7:2]), wr_word[15:8]};
        next_s.bank = wr_word[ptb_pkg::LOW_BANK_BIT];
      end else begin
        next_s.data_b = wr_word[15:1];
        next_s.bank = wr_word[ptb_pkg::LOW_BANK_BIT];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s.cnt <= ptb_pkg::CNT_RST;
      s.bank <= ptb_pkg::BANK_RST;
      s.ctrl <= ptb_pkg::CTRL_RST;
      s.data_a <= ptb_pkg::DATA_RST[15:1];
      s.data_b <= ptb_pkg::DATA_RST[15:1];
      s.temp <= 8'h00;
      s.rdata <= 8'h00;
      s.rvalid <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign o_rdata = s.rdata;
  assign o_rvalid = s.rvalid;

  // two channels on the one shared counter
  ptb_channel u_chan_a (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_count(s.cnt),
    .i_data(s.data_a[15:2]),
    .i_cfs(s.data_a[ptb_pkg::DATA_CFS_BIT]),
    .o_pwm(o_pwm_out_a)
  );

  ptb_channel u_chan_b (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_count(s.cnt),
    .i_data(s.data_b[15:2]),
    .i_cfs(s.data_b[ptb_pkg::DATA_CFS_BIT]),
    .o_pwm(o_pwm_out_b)
  );

  // counter advances by one on a tick without a write
  cnt_advance_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (tick && !(hit && i_wr)) |=> s.cnt == $past(s.cnt) + 14'h0001)
    else $error("counter did not advance on tick");

  cnt_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!tick && !(hit && i_wr)) |=> $stable(s.cnt))
    else $error("counter moved without tick");

  // counter high read returns bits 7..0 and parks low byte
  cnt_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_rd && i_sel_b && !i_sel_a && s.bank && !i_byte_low)
    |=> o_rvalid && s.temp[ptb_pkg::LOW_RSV_BIT] && o_rdata == $past(s.cnt[7:0]))
    else $error("counter high read wrong");

  bank0_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_rd && i_sel_a && !s.bank && !i_byte_low)
    |=> o_rdata == $past(s.data_a[15:8]))
    else $error("bank zero read wrong register");

  ctrl_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_wr && i_sel_a && s.bank && !i_byte_low) |=> s.ctrl == $past(i_wdata))
    else $error("control write lost");

  other_owner_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_bus_interface_enable |=> !o_rvalid && $stable(s.ctrl) && $stable(s.data_a))
    else $error("access taken while addresses handed elsewhere");

  // staged write of the counter: high byte, then low byte
  sequence cnt_hi_wr_s;
    acc && i_wr && i_sel_b && !i_sel_a && s.bank && !i_byte_low;
  endsequence
  sequence cnt_lo_wr_s;
    acc && i_wr && i_sel_b && !i_sel_a && s.bank && i_byte_low;
  endsequence
  staged_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (cnt_hi_wr_s ##1 cnt_lo_wr_s) |=> s.cnt[7:0] == $past(i_wdata, 2)
      && s.cnt[13] == $past(i_wdata[2]))
    else $error("staged counter write wrong");

  // every taken read answers one cycle later, nothing else does
  read_answer_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (hit && i_rd) |=> o_rvalid)
    else $error("read not answered");

  quiet_bus_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !(hit && i_rd) |=> !o_rvalid)
    else $error("answer without read");

  rdata_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !(hit && i_rd) |=> $stable(o_rdata))
    else $error("read data moved without read");

  low_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (hit && i_rd && i_byte_low) |=> o_rdata == $past(s.temp))
    else $error("low read not from staging byte");

  hi_write_stage_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_wr && !i_byte_low && !(i_sel_a && s.bank)) |=> s.temp == $past(i_wdata))
    else $error("high write not staged");

  // control view: byte in high half, low half reads all ones
  ctrl_view_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_rd && !i_wr && i_sel_a && s.bank && !i_byte_low)
    |=> o_rdata == $past(s.ctrl) && s.temp == ptb_pkg::CTRL_LOW_FILL)
    else $error("control view wrong");

  data_a_view_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_rd && !i_wr && i_sel_a && !s.bank && !i_byte_low)
    |=> s.temp[0] && s.temp[7:1] == $past(s.data_a[7:1]))
    else $error("data a low half staged wrong");

  data_b_view_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_rd && !i_wr && i_sel_b && !i_sel_a && !s.bank && !i_byte_low)
    |=> o_rdata == $past(s.data_b[15:8]) && s.temp[0] == $past(s.bank))
    else $error("data b view wrong");

  // counter low half: bits 8..13 reversed, reserved one, bank
  sequence cnt_hi_rd_s;
    acc && i_rd && !i_wr && i_sel_b && !i_sel_a && s.bank && !i_byte_low;
  endsequence
  cnt_low_map_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cnt_hi_rd_s |=> s.temp[7] == $past(s.cnt[8]) && s.temp[6] == $past(s.cnt[9])
      && s.temp[3] == $past(s.cnt[12]) && s.temp[2] == $past(s.cnt[13])
      && s.temp[0] == $past(s.bank))
    else $error("counter low half mapped wrong");

  data_a_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_wr && i_sel_a && !s.bank && i_byte_low)
    |=> s.data_a == $past({s.temp, i_wdata[7:1]}))
    else $error("data a write lost");

  data_b_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_wr && i_sel_b && !i_sel_a && !s.bank && i_byte_low)
    |=> s.data_b == $past({s.temp, i_wdata[7:1]}) && s.bank == $past(i_wdata[0]))
    else $error("data b write lost");

  // one bank shields the other pair from writes
  bank1_data_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (acc && i_wr && s.bank) |=> $stable(s.data_a) && $stable(s.data_b))
    else $error("data written in bank one");

  bank0_ctrl_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !s.bank |=> $stable(s.ctrl))
    else $error("control written in bank zero");

  // counter word commit from staging byte and low byte
  cnt_commit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cnt_lo_wr_s |=> s.cnt[7:0] == $past(s.temp) && s.bank == $past(i_wdata[0]))
    else $error("counter commit wrong");

  cnt_rev_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cnt_lo_wr_s |=> s.cnt[8] == $past(i_wdata[7]) && s.cnt[12] == $past(i_wdata[3]))
    else $error("counter low bits not reversed");

  staged_gap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (cnt_hi_wr_s ##1 !(hit && (i_rd || i_wr)) ##1 cnt_lo_wr_s)
    |=> s.cnt[7:0] == $past(i_wdata, 3))
    else $error("spaced counter write wrong");

  handed_off_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_bus_interface_enable |=> $stable(s.data_b) && $stable(s.bank) && $stable(s.temp))
    else $error("state moved while addresses handed elsewhere");

  // divider: every cycle at select 0, never twice running otherwise
  res_fast_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (counter_clock_select == 3'h0)[*2] |-> tick)
    else $error("no tick at unit resolution");

  res_gap_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    ((counter_clock_select != 3'h0)[*2] ##0 tick) |=> !tick)
    else $error("ticks too close");
endmodule
`default_nettype wire

//--- dv/ptb_filter_model.sv
// low-pass filter stand-in: integrates high time of both outputs
`default_nettype none
module ptb_filter_model (
  // clock and window clear
  input wire logic i_clock,
  input wire logic i_clear,
  // modulated inputs
  input wire logic i_pwm_a,
  input wire logic i_pwm_b,
  // integrated high time
  output logic [31:0] o_high_a,
  output logic [31:0] o_high_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // each pin is filtered on its own
  always @(posedge i_clock) begin
    if (i_clear) begin
      o_high_a <= 32'h0;
      o_high_b <= 32'h0;
    end else begin
      o_high_a <= o_high_a + {31'h0, i_pwm_a};
      o_high_b <= o_high_b + {31'h0, i_pwm_b};
    end
  end
endmodule
`default_nettype wire

//--- dv/test_fourteen_bit_pwm_dac_timebase.sv
// self-checking bench for the pwm time base
`default_nettype none
module test_fourteen_bit_pwm_dac_timebase;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_bus_interface_enable = 1'b0;
  logic i_sel_a = 1'b0;
  logic i_sel_b = 1'b0;
  logic i_byte_low = 1'b0;
  logic i_rd = 1'b0;
  logic i_wr = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic o_rvalid;
  logic o_pwm_out_a;
  logic o_pwm_out_b;
  logic clear = 1'b1;
  logic [31:0] high_a;
  logic [31:0] high_b;
  logic [31:0] lfsr = 32'hDB81159F;
  logic [15:0] w;
  logic [13:0] da;
  logic [13:0] db;
  int errors = 0;
  int total_checks = 0;
  always #20 i_clock = ~i_clock;
  ptb_timebase #(.SLOW_PERIOD(15'h0010)) u_ptb_timebase (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_bus_interface_enable(i_bus_interface_enable),
    .i_sel_a(i_sel_a), .i_sel_b(i_sel_b), .i_byte_low(i_byte_low), .i_rd(i_rd),
    .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_pwm_out_a(o_pwm_out_a), .o_pwm_out_b(o_pwm_out_b));
  ptb_filter_model u_ptb_filter_model (.i_clock(i_clock), .i_clear(clear),
    .i_pwm_a(o_pwm_out_a), .i_pwm_b(o_pwm_out_b), .o_high_a(high_a), .o_high_b(high_b));
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  // counter low byte: bits 8 to 13 reversed, reserved one, bank
  function automatic logic [7:0] cnt_low(input logic [5:0] v, input logic bank);
    return {v[0], v[1], v[2], v[3], v[4], v[5], 1'b1, bank};
  endfunction
  function automatic int period(input int s);
    int t[8] = '{1, 2, 64, 128, 256, 1024, 4096, 16};
    return t[s];
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input logic [31:0] got);
    total_checks++;
    if (got >= lo && got <= hi) begin
    end else begin
      errors++;
      $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic access(input logic a, input logic low, input logic wr, input logic [7:0] wd,
    output logic [7:0] rdv);
    int n;
    @(negedge i_clock);
    i_sel_a = a;
    i_sel_b = ~a;
    i_byte_low = low;
    i_wr = wr;
    i_rd = ~wr;
    i_wdata = wd;
    @(negedge i_clock);
    i_rd = 1'b0;
    i_wr = 1'b0;
    i_sel_a = 1'b0;
    i_sel_b = 1'b0;
    n = 0;
    while (!wr && o_rvalid !== 1'b1 && n < 4) begin
      @(negedge i_clock);
      n++;
    end
    chk("read answer", {7'h00, ~wr}, {7'h00, o_rvalid});
    if (n != 0) begin
      errors++;
      $display("FAIL read latency expected 1 seen %0d", n + 1);
      stop_test();
    end
    rdv = o_rdata;
  endtask
  task automatic wr16(input logic a, input logic [15:0] v);
    logic [7:0] x;
    access(a, 1'b0, 1'b1, v[15:8], x);
    access(a, 1'b1, 1'b1, v[7:0], x);
  endtask
  task automatic rd16(input logic a, output logic [15:0] v);
    access(a, 1'b0, 1'b0, 8'h00, v[15:8]);
    access(a, 1'b1, 1'b0, 8'h00, v[7:0]);
  endtask
  initial begin
    #3000000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge i_clock);
    @(negedge i_clock);
    i_rst_n = 1'b1;
    rd16(1'b1, w);
    chk("control", 8'h00, w[15:8]);
    chk("control low", 8'hFF, w[7:0]);
    access(1'b1, 1'b0, 1'b1, 8'h07, w[7:0]);
    for (int i = 0; i < 3; i++) begin
      lfsr = next_rand(lfsr);
      wr16(1'b0, {8'h00, cnt_low(lfsr[5:0], 1'b1) & 8'hFD});
      rd16(1'b0, w);
      chk_rng("cnt high", 0, 1, {24'h0, w[15:8]});
      chk("cnt low", cnt_low(lfsr[5:0], 1'b1), w[7:0]);
    end
    for (int s = 0; s < 8; s++) begin
      access(1'b1, 1'b0, 1'b1, s[7:0], w[7:0]);
      wr16(1'b0, 16'h0001);
      repeat (4 * period(s)) @(negedge i_clock);
      access(1'b0, 1'b0, 1'b0, 8'h00, w[15:8]);
      chk_rng("rate", 3, 7, {24'h0, w[15:8]});
    end
    access(1'b1, 1'b0, 1'b1, 8'h00, w[7:0]);
    access(1'b0, 1'b1, 1'b1, 8'h00, w[7:0]);
    lfsr = next_rand(lfsr);
    da = (lfsr[13:0] | 14'h0100) & 14'h3FFC;
    db = lfsr[29:16] | 14'h0101;
    wr16(1'b1, {da, 2'b01});
    wr16(1'b0, {db, 2'b10});
    rd16(1'b1, w);
    chk("data a", {da[5:0], 2'b01}, w[7:0]);
    chk("data a hi", da[13:6], w[15:8]);
    rd16(1'b0, w);
    chk("data b", {db[5:0], 2'b10}, w[7:0]);
    @(negedge i_clock);
    clear = 1'b0;
    repeat (16384) @(negedge i_clock);
    chk_rng("duty a", da - 128, da + 128, high_a);
    chk_rng("duty b", db - 128, db + 128, high_b);
    wr16(1'b1, {14'h0040, 2'b00});
    @(negedge i_clock);
    clear = 1'b1;
    @(negedge i_clock);
    clear = 1'b0;
    repeat (300) @(negedge i_clock);
    chk_rng("held a", 0, 0, high_a);
    access(1'b0, 1'b1, 1'b1, 8'h01, w[7:0]);
    i_bus_interface_enable = 1'b1;
    access(1'b1, 1'b0, 1'b1, 8'h05, w[7:0]);
    @(negedge i_clock);
    i_sel_a = 1'b1;
    i_rd = 1'b1;
    @(negedge i_clock);
    i_sel_a = 1'b0;
    i_rd = 1'b0;
    chk("refused", 8'h00, {7'h00, o_rvalid});
    i_bus_interface_enable = 1'b0;
    access(1'b1, 1'b0, 1'b0, 8'h00, w[7:0]);
    chk("control kept", 8'h00, w[7:0]);
    stop_test();
  end
endmodule
`default_nettype wire
